/* File: logic/standby_and_block_gating_ctrl.sv */
// Standby mode control, stop unlock, reset vector choice and per-block
// disable gating for a small microcontroller, behind an Avalon-MM slave.
// Assumes the CPU side delivers pending and enabled interrupt vectors on
// this clock, and the external wake pin arrives asynchronously.
//
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module standby_and_block_gating_ctrl
(
    input  wire logic                                      CLOCK_IN,
    input  wire logic                                      RESET_N_IN,
    // Avalon-MM slave
    input  wire logic [standby_gate_pkg::ADDR_W-1:0]       AVS_ADDRESS_IN,
    input  wire logic                                      AVS_READ_IN,
    input  wire logic                                      AVS_WRITE_IN,
    input  wire logic [standby_gate_pkg::DATA_W-1:0]       AVS_WRITEDATA_IN,
    input  wire logic [3:0]                                AVS_BYTEENABLE_IN,
    output logic      [standby_gate_pkg::DATA_W-1:0]       AVS_READDATA_OUT,
    output logic                                           AVS_WAITREQUEST_OUT,
    // Wake sources
    input  wire logic                                      WDT_IRQ_IN,
    input  wire logic [standby_gate_pkg::IRQ_W-1:0]        IRQ_PENDING_IN,
    input  wire logic [standby_gate_pkg::IRQ_W-1:0]        IRQ_ENABLE_IN,
    input  wire logic                                      EXT_PIN_IRQ_IN,
    input  wire logic                                      EXT_PIN_IRQ_EN_IN,
    // Reset cause, held stable by the reset controller across reset
    input  wire logic                                      RESET_BY_BREAK_IN,
    input  wire logic [1:0]                                BREAK_LEVEL_IN,
    // Peripheral register write strobes, one per gated block
    input  wire logic [standby_gate_pkg::NUM_BLOCKS-1:0]   PERIPH_WR_IN,
    output logic      [standby_gate_pkg::NUM_BLOCKS-1:0]   PERIPH_WR_OUT,
    output logic      [standby_gate_pkg::NUM_BLOCKS-1:0]   BLOCK_RESET_N_OUT,
    output logic      [standby_gate_pkg::NUM_BLOCKS-1:0]   BLOCK_CLK_EN_OUT,
    // Core and oscillator control
    output logic                                           CPU_RUN_OUT,
    output logic                                           LS_OSC_RUN_OUT,
    output logic                                           HS_OSC_RUN_OUT,
    output logic      [15:0]                               VECTOR_LO_ADDR_OUT,
    output logic      [15:0]                               VECTOR_HI_ADDR_OUT
);

    // Register hit on a bus address
    function automatic logic reg_hit(input logic [standby_gate_pkg::ADDR_W-1:0] addr,
                                     input logic [15:0] idx);
        reg_hit = (addr[standby_gate_pkg::ADDR_W-1:standby_gate_pkg::IDX_LSB] == idx);
    endfunction

    logic                                        ack_r;
    logic                                        bus_req;
    logic                                        wr_fire;
    logic [standby_gate_pkg::REG_W-1:0]          wr_byte;
    logic [standby_gate_pkg::DATA_W-1:0]         readdata_r;
    logic [standby_gate_pkg::DATA_W-1:0]         readdata_nxt;
    logic [standby_gate_pkg::REG_W-1:0]          comparator_gate_r;
    logic [standby_gate_pkg::REG_W-1:0]          converter_gate_r;
    logic [standby_gate_pkg::REG_W-1:0]          timer16_gate_r;
    logic [standby_gate_pkg::REG_W-1:0]          pwm_gate_r;
    logic [standby_gate_pkg::NUM_BLOCKS-1:0]     block_disable;
    standby_gate_pkg::unlock_e                   unlock_r;
    standby_gate_pkg::mode_e                     mode_r;
    logic                                        wake_neg_r;
    logic                                        halt_wake;
    logic                                        halt_bit;
    logic [2:0]                                  ext_sync_r;
    logic                                        ext_level_r;
    logic                                        stop_wake;
    logic                                        standby_wr;
    logic                                        unlock_wr;
    logic                                        vec_captured_r;
    logic                                        break_vec_r;

    // One wait cycle: request seen at edge 0, completes at edge 1
    assign bus_req             = AVS_READ_IN | AVS_WRITE_IN;
    assign AVS_WAITREQUEST_OUT = bus_req & ~ack_r;
    assign wr_fire             = AVS_WRITE_IN & ack_r & AVS_BYTEENABLE_IN[0];
    assign wr_byte             = AVS_WRITEDATA_IN[standby_gate_pkg::REG_W-1:0];
    assign AVS_READDATA_OUT    = readdata_r;

    // Acknowledge pulse; drops after the completing edge so requests may chain
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            ack_r <= 1'b0;
        else
            ack_r <= bus_req & ~ack_r;
    end

    // Read mux; write-only registers and unmapped addresses read zero
    always_comb
    begin
        readdata_nxt = '0;
        if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_COMPARATOR))
            readdata_nxt[standby_gate_pkg::REG_W-1:0] = comparator_gate_r;
        else if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_CONVERTER))
            readdata_nxt[standby_gate_pkg::REG_W-1:0] = converter_gate_r;
        else if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_TIMER16))
            readdata_nxt[standby_gate_pkg::REG_W-1:0] = timer16_gate_r;
        else if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_PWM))
            readdata_nxt[standby_gate_pkg::REG_W-1:0] = pwm_gate_r;
        else if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_STATUS))
        begin
            readdata_nxt[standby_gate_pkg::ST_HALT_BIT]      = halt_bit;
            readdata_nxt[standby_gate_pkg::ST_STOP_BIT]      =
                (mode_r == standby_gate_pkg::MODE_STOP);
            readdata_nxt[standby_gate_pkg::ST_FIRST_BIT]     =
                (unlock_r == standby_gate_pkg::UNLOCK_FIRST);
            readdata_nxt[standby_gate_pkg::ST_ARMED_BIT]     =
                (unlock_r == standby_gate_pkg::UNLOCK_ARMED);
            readdata_nxt[standby_gate_pkg::ST_BREAK_VEC_BIT] = break_vec_r;
        end
    end

    // Read data captured in the wait cycle, stands at the completing edge
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            readdata_r <= '0;
        else if (AVS_READ_IN & ~ack_r)
            readdata_r <= readdata_nxt;
    end

    // Gating registers; only assigned bits are stored
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            comparator_gate_r <= standby_gate_pkg::GATE_RESET;
            converter_gate_r  <= standby_gate_pkg::GATE_RESET;
            timer16_gate_r    <= standby_gate_pkg::GATE_RESET;
            pwm_gate_r        <= standby_gate_pkg::GATE_RESET;
        end
        else if (wr_fire)
        begin
            if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_COMPARATOR))
                comparator_gate_r <= wr_byte & standby_gate_pkg::COMPARATOR_MASK;
            if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_CONVERTER))
                converter_gate_r  <= wr_byte & standby_gate_pkg::CONVERTER_MASK;
            if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_TIMER16))
                timer16_gate_r    <= wr_byte & standby_gate_pkg::TIMER16_MASK;
            if (reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_PWM))
                pwm_gate_r        <= wr_byte & standby_gate_pkg::PWM_MASK;
        end
    end

    // Collect the disable flags into one per-block vector
    assign block_disable[0] = comparator_gate_r[standby_gate_pkg::COMPARATOR_BIT];
    assign block_disable[1] = converter_gate_r[standby_gate_pkg::CONVERTER_BIT];
    assign block_disable[standby_gate_pkg::TIMER_BASE +: standby_gate_pkg::GROUP_W] =
        timer16_gate_r[standby_gate_pkg::GROUP_W-1:0];
    assign block_disable[standby_gate_pkg::PWM_BASE +: standby_gate_pkg::GROUP_W] =
        pwm_gate_r[standby_gate_pkg::GROUP_W-1:0];

    // Per-block reset, clock enable and write filtering.
    // The clock is offered as an enable for a glitch-free gate cell nearby,
    // since gating a clock in plain logic here would invite glitches.
    generate
        for (genvar b = 0; b < standby_gate_pkg::NUM_BLOCKS; b++)
        begin : g_block
            assign BLOCK_RESET_N_OUT[b] = ~block_disable[b];
            assign BLOCK_CLK_EN_OUT[b]  = ~block_disable[b] &
                                          (mode_r != standby_gate_pkg::MODE_STOP);
            assign PERIPH_WR_OUT[b]     = PERIPH_WR_IN[b] & ~block_disable[b];
        end
    endgenerate

    // External wake pin: three flops, a change counts once stages 2 and 3 agree
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            ext_sync_r  <= 3'h0;
            ext_level_r <= 1'b0;
        end
        else
        begin
            ext_sync_r <= {ext_sync_r[1:0], EXT_PIN_IRQ_IN};
            if (ext_sync_r[1] == ext_sync_r[2])
                ext_level_r <= ext_sync_r[2];
        end
    end

    // Wake conditions
    assign halt_wake  = WDT_IRQ_IN | (|(IRQ_PENDING_IN & IRQ_ENABLE_IN));
    assign stop_wake  = ext_level_r & EXT_PIN_IRQ_EN_IN;
    assign standby_wr = wr_fire & reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_STANDBY_CTRL);
    assign unlock_wr  = wr_fire & reg_hit(AVS_ADDRESS_IN, standby_gate_pkg::IDX_STOP_UNLOCK);

    // Stop unlock sequencer; entering STOP wins over any concurrent unlock write
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            unlock_r <= standby_gate_pkg::UNLOCK_IDLE;
        else if (standby_wr & wr_byte[standby_gate_pkg::STOP_BIT] &
                 ~wr_byte[standby_gate_pkg::HALT_BIT] &
                 (unlock_r == standby_gate_pkg::UNLOCK_ARMED) & ~stop_wake)
            unlock_r <= standby_gate_pkg::UNLOCK_IDLE;
        else if (unlock_wr)
        begin
            case (unlock_r)
                standby_gate_pkg::UNLOCK_IDLE:
                    if (wr_byte[7:4] == standby_gate_pkg::UNLOCK_FIRST_HI)
                        unlock_r <= standby_gate_pkg::UNLOCK_FIRST;
                standby_gate_pkg::UNLOCK_FIRST:
                    if (wr_byte[7:4] == standby_gate_pkg::UNLOCK_SECOND_HI)
                        unlock_r <= standby_gate_pkg::UNLOCK_ARMED;
                    else if (wr_byte[7:4] == standby_gate_pkg::UNLOCK_FIRST_HI)
                        unlock_r <= standby_gate_pkg::UNLOCK_FIRST;
                    else
                        unlock_r <= standby_gate_pkg::UNLOCK_IDLE;
                standby_gate_pkg::UNLOCK_ARMED:
                    unlock_r <= standby_gate_pkg::UNLOCK_ARMED;
                default:
                    unlock_r <= standby_gate_pkg::UNLOCK_IDLE;
            endcase
        end
    end

    // Halt release sampled on the falling edge, so the halt bit drops there
    always_ff @(negedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            wake_neg_r <= 1'b0;
        else
            wake_neg_r <= (mode_r == standby_gate_pkg::MODE_HALT) & halt_wake;
    end

    assign halt_bit = (mode_r == standby_gate_pkg::MODE_HALT) & ~wake_neg_r;

    // Operating mode; entry is refused while a wake source already pends,
    // otherwise the core could sleep through an interrupt it cannot see
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
            mode_r <= standby_gate_pkg::MODE_RUN;
        else
        begin
            case (mode_r)
                standby_gate_pkg::MODE_RUN:
                    if (standby_wr)
                    begin
                        // Both bits together is a prohibited setting: ignored
                        if (wr_byte[standby_gate_pkg::HALT_BIT] &
                            ~wr_byte[standby_gate_pkg::STOP_BIT] & ~halt_wake)
                            mode_r <= standby_gate_pkg::MODE_HALT;
                        else if (wr_byte[standby_gate_pkg::STOP_BIT] &
                                 ~wr_byte[standby_gate_pkg::HALT_BIT] &
                                 (unlock_r == standby_gate_pkg::UNLOCK_ARMED) &
                                 ~stop_wake)
                            mode_r <= standby_gate_pkg::MODE_STOP;
                    end
                standby_gate_pkg::MODE_HALT:
                    if (wake_neg_r)
                        mode_r <= standby_gate_pkg::MODE_RUN;
                standby_gate_pkg::MODE_STOP:
                    if (stop_wake)
                        mode_r <= standby_gate_pkg::MODE_RUN;
                default:
                    mode_r <= standby_gate_pkg::MODE_RUN;
            endcase
        end
    end

    // Core and oscillators: halt stops only the core, stop stops everything
    assign CPU_RUN_OUT    = ~halt_bit & (mode_r != standby_gate_pkg::MODE_STOP);
    assign LS_OSC_RUN_OUT = (mode_r != standby_gate_pkg::MODE_STOP);
    assign HS_OSC_RUN_OUT = (mode_r != standby_gate_pkg::MODE_STOP);

    // Reset cause captured at the first edge after release, not under reset
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            vec_captured_r <= 1'b0;
            break_vec_r    <= 1'b0;
        end
        else if (!vec_captured_r)
        begin
            vec_captured_r <= 1'b1;
            break_vec_r    <= RESET_BY_BREAK_IN &
                              (BREAK_LEVEL_IN < standby_gate_pkg::BREAK_LEVEL_LIMIT);
        end
    end

    // Start address words for the core's vector fetch
    always_ff @(posedge CLOCK_IN or negedge RESET_N_IN)
    begin
        if (!RESET_N_IN)
        begin
            VECTOR_LO_ADDR_OUT <= standby_gate_pkg::VEC_NORMAL_LO;
            VECTOR_HI_ADDR_OUT <= standby_gate_pkg::VEC_NORMAL_HI;
        end
        else if (break_vec_r)
        begin
            VECTOR_LO_ADDR_OUT <= standby_gate_pkg::VEC_BREAK_LO;
            VECTOR_HI_ADDR_OUT <= standby_gate_pkg::VEC_BREAK_HI;
        end
        else
        begin
            VECTOR_LO_ADDR_OUT <= standby_gate_pkg::VEC_NORMAL_LO;
            VECTOR_HI_ADDR_OUT <= standby_gate_pkg::VEC_NORMAL_HI;
        end
    end

endmodule

`default_nettype wire

/* File: logic/standby_gate_pkg.sv */
// Constants for the standby and block gating controller.
// Assumes one system clock and an Avalon-MM slave port whose
// byte address is four times the register index.
package standby_gate_pkg;

    // Register indices; byte address is index times four
    localparam logic [15:0] IDX_STOP_UNLOCK   = 16'hF008;
    localparam logic [15:0] IDX_STANDBY_CTRL  = 16'hF009;
    localparam logic [15:0] IDX_COMPARATOR    = 16'hF06B;
    localparam logic [15:0] IDX_CONVERTER     = 16'hF06C;
    localparam logic [15:0] IDX_TIMER16       = 16'hF06E;
    localparam logic [15:0] IDX_PWM           = 16'hF06F;
    localparam logic [15:0] IDX_STATUS        = 16'hF0A0;

    // Bus geometry
    localparam int          ADDR_W            = 18;
    localparam int          IDX_LSB           = 2;
    localparam int          DATA_W            = 32;
    localparam int          REG_W             = 8;

    // Gating register reset values and writable masks
    localparam logic [7:0]  GATE_RESET        = 8'h00;
    localparam logic [7:0]  COMPARATOR_MASK   = 8'h40;
    localparam logic [7:0]  CONVERTER_MASK    = 8'h01;
    localparam logic [7:0]  TIMER16_MASK      = 8'h0F;
    localparam logic [7:0]  PWM_MASK          = 8'h0F;

    // Field positions
    localparam int          COMPARATOR_BIT    = 6;
    localparam int          CONVERTER_BIT     = 0;
    localparam int          HALT_BIT          = 0;
    localparam int          STOP_BIT          = 1;

    // Gated blocks: 0 comparator, 1 adc, 2..5 timer 8,9,A,B, 6..9 pwm 4..7
    localparam int          NUM_BLOCKS        = 10;
    localparam int          TIMER_BASE        = 2;
    localparam int          PWM_BASE          = 6;
    localparam int          GROUP_W           = 4;

    // Stop unlock codes, upper nibble only, lower nibble is free
    localparam logic [3:0]  UNLOCK_FIRST_HI   = 4'h5;
    localparam logic [3:0]  UNLOCK_SECOND_HI  = 4'hA;

    // Reset start address words
    localparam logic [15:0] VEC_NORMAL_LO     = 16'h0002;
    localparam logic [15:0] VEC_NORMAL_HI     = 16'h0003;
    localparam logic [15:0] VEC_BREAK_LO      = 16'h0004;
    localparam logic [15:0] VEC_BREAK_HI      = 16'h0005;
    localparam logic [1:0]  BREAK_LEVEL_LIMIT = 2'h2;

    // Interrupt widths
    localparam int          IRQ_W             = 16;

    // Status register layout
    localparam int          ST_HALT_BIT       = 0;
    localparam int          ST_STOP_BIT       = 1;
    localparam int          ST_FIRST_BIT      = 2;
    localparam int          ST_ARMED_BIT      = 3;
    localparam int          ST_BREAK_VEC_BIT  = 4;

    typedef enum logic [1:0] {MODE_RUN, MODE_HALT, MODE_STOP} mode_e;
    typedef enum logic [1:0] {UNLOCK_IDLE, UNLOCK_FIRST, UNLOCK_ARMED} unlock_e;

endpackage

/* File: tb/standby_gate_chk.sv */
// Port checker for the standby and block gating controller.
// Assumes one system clock and an asynchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module standby_gate_chk
(
    input wire logic        CLOCK_IN,
    input wire logic        RESET_N_IN,
    input wire logic [31:0] AVS_READDATA_OUT,
    input wire logic        AVS_READ_IN,
    input wire logic        AVS_WAITREQUEST_OUT,
    input wire logic        WDT_IRQ_IN,
    input wire logic        EXT_PIN_IRQ_IN,
    input wire logic        EXT_PIN_IRQ_EN_IN,
    input wire logic [9:0]  PERIPH_WR_IN,
    input wire logic [9:0]  PERIPH_WR_OUT,
    input wire logic [9:0]  BLOCK_RESET_N_OUT,
    input wire logic [9:0]  BLOCK_CLK_EN_OUT,
    input wire logic        CPU_RUN_OUT,
    input wire logic        LS_OSC_RUN_OUT,
    input wire logic        HS_OSC_RUN_OUT,
    input wire logic [15:0] VECTOR_LO_ADDR_OUT,
    input wire logic [15:0] VECTOR_HI_ADDR_OUT
);
    default clocking cb @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    // Strobes and clocks follow the disable flags, read back as block resets
    property p_wr_drop; PERIPH_WR_OUT == (PERIPH_WR_IN & BLOCK_RESET_N_OUT); endproperty
    a_wr_drop: assert property (p_wr_drop) else $error("strobe passed to disabled block");
    property p_clk_stop; (BLOCK_CLK_EN_OUT & ~BLOCK_RESET_N_OUT) == 10'h000; endproperty
    a_clk_stop: assert property (p_clk_stop) else $error("clock runs in held block");
    property p_gate_reset; $rose(RESET_N_IN) |-> &BLOCK_RESET_N_OUT; endproperty
    a_gate_reset: assert property (p_gate_reset) else $error("block held after reset");
    property p_rd_upper; AVS_READ_IN && !AVS_WAITREQUEST_OUT |-> AVS_READDATA_OUT[31:8] == 24'h0;
    endproperty
    a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
    // Only the two documented start address pairs may appear
    property p_vec_pair;
        {VECTOR_HI_ADDR_OUT, VECTOR_LO_ADDR_OUT} inside {32'h00030002, 32'h00050004};
    endproperty
    a_vec_pair: assert property (p_vec_pair) else $error("bad start address pair");
    // Everything stops together in STOP
    property p_stop_all;
        !LS_OSC_RUN_OUT |-> !HS_OSC_RUN_OUT && !CPU_RUN_OUT && BLOCK_CLK_EN_OUT == 10'h000;
    endproperty
    a_stop_all: assert property (p_stop_all) else $error("activity left in stop");
    property p_halt_periph; !CPU_RUN_OUT && LS_OSC_RUN_OUT |-> BLOCK_CLK_EN_OUT == BLOCK_RESET_N_OUT;
    endproperty
    a_halt_periph: assert property (p_halt_periph) else $error("peripheral stopped in halt");
    property p_halt_wake; !CPU_RUN_OUT && LS_OSC_RUN_OUT && WDT_IRQ_IN |-> ##[1:2] CPU_RUN_OUT;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("halt not released");
    // Synchroniser delay allows a few edges before the oscillators return
    property p_pin_wake; !LS_OSC_RUN_OUT && EXT_PIN_IRQ_IN && EXT_PIN_IRQ_EN_IN |-> ##[1:6] LS_OSC_RUN_OUT;
    endproperty
    a_pin_wake: assert property (p_pin_wake) else $error("stop not released");

    c_stop: cover property ($fell(LS_OSC_RUN_OUT));
    c_halt: cover property (!CPU_RUN_OUT && LS_OSC_RUN_OUT);
    c_gate: cover property (BLOCK_RESET_N_OUT != 10'h3FF);
endmodule

`default_nettype wire

/* File: tb/test_standby_and_block_gating_ctrl.sv */
// Self-checking bench for the standby and block gating controller.
// Assumes the Avalon slave answers after a wait state, as the design notes state.
`timescale 1ns/100ps
`default_nettype none

module test_standby_and_block_gating_ctrl;
    localparam logic [15:0] UNLK = standby_gate_pkg::IDX_STOP_UNLOCK;
    localparam logic [15:0] STBY = standby_gate_pkg::IDX_STANDBY_CTRL;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [17:0] addr = 18'h00000;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic        wdt = 1'b0;
    logic [15:0] pend = 16'h0000;
    logic [15:0] ien = 16'h0000;
    logic        pin = 1'b0;
    logic        pin_en = 1'b1;
    logic        break_instruction = 1'b0;
    logic [1:0]  lvl = 2'h0;
    logic [9:0]  pwr = 10'h000;
    logic [31:0] rdata;
    logic        waitreq;
    logic [9:0]  pwr_out;
    logic [9:0]  blk_rst_n;
    logic [9:0]  clk_en;
    logic        cpu_run;
    logic        ls_osc;
    logic        hs_osc;
    logic [15:0] vlo;
    logic [15:0] vhi;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    // Gating table: index, value written, value read back
    logic [15:0] gidx [4] = '{standby_gate_pkg::IDX_COMPARATOR, standby_gate_pkg::IDX_CONVERTER,
                              standby_gate_pkg::IDX_TIMER16, standby_gate_pkg::IDX_PWM};
    logic [7:0]  gw [4] = '{8'hFF, 8'hFF, 8'hF5, 8'hFA};
    logic [7:0]  gr [4] = '{8'h40, 8'h01, 8'h05, 8'h0A};

    standby_and_block_gating_ctrl dut
    (
        .CLOCK_IN(clk), .RESET_N_IN(rst_n), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd),
        .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata), .AVS_BYTEENABLE_IN(4'hF),
        .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq), .WDT_IRQ_IN(wdt),
        .IRQ_PENDING_IN(pend), .IRQ_ENABLE_IN(ien), .EXT_PIN_IRQ_IN(pin),
        .EXT_PIN_IRQ_EN_IN(pin_en), .RESET_BY_BREAK_IN(break_instruction), .BREAK_LEVEL_IN(lvl),
        .PERIPH_WR_IN(pwr), .PERIPH_WR_OUT(pwr_out), .BLOCK_RESET_N_OUT(blk_rst_n),
        .BLOCK_CLK_EN_OUT(clk_en), .CPU_RUN_OUT(cpu_run), .LS_OSC_RUN_OUT(ls_osc),
        .HS_OSC_RUN_OUT(hs_osc), .VECTOR_LO_ADDR_OUT(vlo), .VECTOR_HI_ADDR_OUT(vhi)
    );

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic wrap_up;
        if (failures == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cycle ceiling well above the few hundred cycles the run needs
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic do_reset(input logic b, input logic [1:0] l);
        @(posedge clk);
        rst_n <= 1'b0;
        break_instruction   <= b;
        lvl   <= l;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(negedge clk);
    endtask

    // Request held until waitrequest is sampled low at a rising edge; values read
    // right after the edge are still the pre-edge ones, since the design updates by NBA
    task automatic bus(input logic w, input logic [15:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        addr  <= {idx, 2'b00};
        wdata <= {24'h000000, d};
        rd    <= ~w;
        wr    <= w;
        @(posedge clk);
        while (waitreq)
            @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic wrt(input logic [15:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask

    task automatic rdc(input logic [15:0] idx, input logic [7:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        chk(q, {24'h000000, e});
    endtask

    task automatic halt_wake(input int src);
        wrt(STBY, 8'h01);
        repeat (2) @(negedge clk); // Bus stays quiet, as for the two no-ops
        chk(32'({cpu_run, ls_osc, clk_en}), 32'({2'b01, 10'h3FF}));
        @(posedge clk);
        wdt     <= (src == 0);
        pend[3] <= (src == 1);
        ien[3]  <= (src == 1);
        repeat (3) @(negedge clk);
        chk({31'h0, cpu_run}, 32'h1);
        @(posedge clk);
        wdt  <= 1'b0;
        pend <= 16'h0000;
        ien  <= 16'h0000;
    endtask

    // Two unlock writes, then a stop request; s says whether STOP must follow
    task automatic stop_seq(input logic [7:0] a, input logic [7:0] b, input logic s);
        wrt(UNLK, a);
        wrt(UNLK, b);
        wrt(STBY, 8'h02);
        repeat (2) @(negedge clk);
        chk(32'({ls_osc, hs_osc, cpu_run}), 32'({3{~s}}));
        if (s)
        begin
            chk(32'(clk_en), 32'h00000000);
            @(posedge clk);
            pin <= 1'b1;
            repeat (8) @(negedge clk);
            chk(32'({ls_osc, cpu_run}), 32'h00000003);
            @(posedge clk);
            pin <= 1'b0;
        end
    endtask

    initial
    begin
        do_reset(1'b0, 2'h0);
        chk({vhi, vlo}, 32'h00030002);
        for (int i = 0; i < 4; i++)
            rdc(gidx[i], 8'h00);
        for (int i = 0; i < 4; i++)
            wrt(gidx[i], gw[i]);
        for (int i = 0; i < 4; i++)
            rdc(gidx[i], gr[i]);
        rdc(16'hF06D, 8'h00);
        pwr <= 10'h3FF;
        @(negedge clk);
        chk(32'({blk_rst_n, clk_en, pwr_out}), 32'({3{10'h168}}));
        for (int i = 0; i < 4; i++)
            wrt(gidx[i], 8'h00);
        @(negedge clk);
        chk(32'({blk_rst_n, pwr_out}), 32'({2{10'h3FF}}));
        pwr <= 10'h000;
        halt_wake(0);
        halt_wake(1);
        stop_seq(8'h33, 8'hA3, 1'b0);
        wrt(UNLK, 8'h5C);
        stop_seq(8'h33, 8'hA3, 1'b0);
        stop_seq(8'h53, 8'hA7, 1'b1);
        stop_seq(8'h00, 8'h00, 1'b0);
        wrt(UNLK, 8'h50);
        wrt(UNLK, 8'hAF);
        wrt(STBY, 8'h03);
        rdc(standby_gate_pkg::IDX_STATUS, 8'h08);
        wrt(standby_gate_pkg::IDX_PWM, 8'h0F);
        do_reset(1'b1, 2'h1);
        chk({vhi, vlo}, 32'h00050004);
        chk(32'(blk_rst_n), 32'h000003FF);
        rdc(standby_gate_pkg::IDX_STATUS, 8'h10);
        stop_seq(8'h00, 8'h00, 1'b0);
        do_reset(1'b1, 2'h2);
        chk({vhi, vlo}, 32'h00030002);
        wrap_up();
    end
endmodule

bind standby_and_block_gating_ctrl standby_gate_chk u_chk
(
    .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_READ_IN(AVS_READ_IN), .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT), .WDT_IRQ_IN(WDT_IRQ_IN),
    .EXT_PIN_IRQ_IN(EXT_PIN_IRQ_IN), .EXT_PIN_IRQ_EN_IN(EXT_PIN_IRQ_EN_IN),
    .PERIPH_WR_IN(PERIPH_WR_IN), .PERIPH_WR_OUT(PERIPH_WR_OUT),
    .BLOCK_RESET_N_OUT(BLOCK_RESET_N_OUT), .BLOCK_CLK_EN_OUT(BLOCK_CLK_EN_OUT),
    .CPU_RUN_OUT(CPU_RUN_OUT), .LS_OSC_RUN_OUT(LS_OSC_RUN_OUT), .HS_OSC_RUN_OUT(HS_OSC_RUN_OUT),
    .VECTOR_LO_ADDR_OUT(VECTOR_LO_ADDR_OUT), .VECTOR_HI_ADDR_OUT(VECTOR_HI_ADDR_OUT)
);

`default_nettype wire
